// *** rtl/rbcs_map.vh ***
/*
  Constants for the reset, boot and clock sequencer: timing counts in input clock
  cycles except the boot wait in system cycles, reset values of the external-interface clock-divide bits, field widths.
  Assumes every count except the boot wait is in cycles of the block clock, which stands for the input clock.
*/
`ifndef RBCS_MAP_VH
`define RBCS_MAP_VH

// Timing counts, input clock cycles; boot wait in system cycles
`define RBCS_WD_PULSE_CYC 16'd512
`define RBCS_BUS_VALID_CYC 16'd32
`define RBCS_STRAP_HOLD_CYC 16'd16
`define RBCS_BOOT_SYS_CYC 16'd1260
`define RBCS_BOOT_HOLD_CYC 16'd2520
`define RBCS_PLL_LOCK_CYC 18'd131072
`define RBCS_WARM_RST_MIN_CYC 16'd8
`define RBCS_CNT_W 18

// External-interface clock-divide bits, reset values
`define RBCS_XIF_TIM_HALF_RST 1'b1
`define RBCS_XIF_OUT_HALF_RST 1'b1
`define RBCS_CLKOUT_DIV_RST 5'h04

// Multiplier field
`define RBCS_MULT_W 4
`define RBCS_MULT_RST 4'h0

// System clock selection codes
`define RBCS_SYS_DIRECT 2'h0
`define RBCS_SYS_BYPASS 2'h1
`define RBCS_SYS_PLL 2'h2

`endif

// *** rtl/rbcs_delay.v ***
/*
  Counting delay: pulses done_o once, cnt_i cycles after start_i, with busy_o high
  while counting. A step input lets the count advance at a reduced rate.
  Assumes synchronous start and a stable cnt_i while busy.
*/
`timescale 1ns/10ps
module rbcs_delay #(
  parameter W = 18
) (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Control
  input wire start_i,
  input wire step_i,
  input wire [W-1:0] cnt_i,
  // Status
  output wire busy_o,
  output wire done_o
);
  reg [W-1:0] cnt_ff;
  reg busy_ff;
  reg done_ff;
  wire last;

  assign last = (cnt_ff <= {{(W-1){1'b0}}, 1'b1});
  assign busy_o = busy_ff;
  assign done_o = done_ff;

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt_ff <= {W{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (start_i)
    begin
      cnt_ff <= cnt_i;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end
    else if (busy_ff && step_i)
    begin
      cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      busy_ff <= !last;
      done_ff <= last;
    end
    else
    begin
      done_ff <= 1'b0;
    end
  end
endmodule // rbcs_delay

// *** rtl/rbcs_seq.v ***
/*
  Reset, boot and clock sequencer: synchronises the external reset, stretches
  watchdog resets, latches the straps, times bus start, boot-pin sampling and
  PLL lock, and selects system and output clock division ratios.
  Assumes clk_i is the input clock and the board supervisor obeys its timing.
//
// Contract
// RULE1: Supervisor keeps input clock stable 8 cycles before releasing reset.
// RULE2: Warm reset held low at least 8 input clock cycles.
// RULE3: Watchdog reset drives a 512-cycle reset pulse.
// RULE4: Bus address and data valid 32 cycles after reset release.
// RULE5: PLL-disable strap set 16 cycles before, held 16 after release.
// RULE6: Memory-map-mode strap stable 16 cycles after reset release.
// RULE7: Boot-mode pins held 2520 input cycles after release.
// RULE8: Boot code waits 1260 system cycles, at half input rate, before sampling.
// RULE9: Sampled boot pins choose destination memory or a ROM boot function.
// RULE10: Boot wait without power-on reset scales with current system clock.
// RULE11: Both clock-divide bits reset to one: clock out is input over eight.
// RULE12: After multiplier change, wait 131072 input cycles for PLL lock.
// RULE13: With external clock, reset held 1 ms after core supply ready.
// RULE14: PLL not disabled: start in bypass, system clock is input over two.
// RULE15: Non-zero multiplier n enables PLL: system clock is input times n halved.
// RULE16: PLL-disable strap low at reset: PLL off, system clock equals input.
// RULE17: External reset release synchronised before post-reset counters start.
*/
`timescale 1ns/10ps
`include "rbcs_map.vh"
module rbcs_seq (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Board pins
  input wire ext_reset_n_i,
  input wire pll_disable_strap_n_i,
  input wire memory_map_mode_strap_i,
  input wire [3:0] boot_mode_i,
  // Watchdog and debugger
  input wire wd_trigger_i,
  input wire debug_boot_i,
  // Software controls
  input wire mult_wr_i,
  input wire [`RBCS_MULT_W-1:0] mult_i,
  input wire xif_wr_i,
  input wire xif_timing_clock_half_i,
  input wire xif_clock_out_half_i,
  // Reset outputs
  output wire core_reset_o,
  output wire wd_reset_n_o,
  output wire wd_reset_oe_n_o,
  output reg bus_valid_o,
  // Strap and boot results
  output reg pll_disabled_o,
  output reg memory_map_mode_o,
  output reg [3:0] boot_mode_o,
  output reg boot_sampled_o,
  output reg boot_to_rom_o,
  // Clock control
  output reg [`RBCS_MULT_W-1:0] pll_multiplier_reg_o,
  output reg [1:0] sys_clk_sel_o,
  output reg pll_locked_o,
  output reg xif_timing_clock_half_o,
  output reg xif_clock_out_half_o,
  output reg [4:0] clkout_div_o
);
  localparam S_RESET = 4'b0001;
  localparam S_STRAP = 4'b0010;
  localparam S_BOOT = 4'b0100;
  localparam S_RUN = 4'b1000;

  reg rst_s1_ff;
  reg rst_s2_ff;
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg sys_ph_ff;
  wire in_reset;
  wire wd_busy;
  wire bus_done;
  wire strap_done;
  wire boot_done;
  wire lock_busy;
  wire lock_done;
  wire boot_step;
  wire rel_start;

  // Two-stage sync of the external reset
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= ext_reset_n_i; // RULE17
      rst_s2_ff <= rst_s1_ff; // RULE17
    end
  end

  // Watchdog pulse holds the device in reset, as does the external pin
  assign in_reset = !rst_s2_ff || wd_busy; // RULE2 RULE13
  assign core_reset_o = (state_ff == S_RESET);
  assign wd_reset_n_o = 1'b0;
  assign wd_reset_oe_n_o = !wd_busy; // RULE3
  assign rel_start = (state_ff == S_RESET) && !in_reset;

  rbcs_delay #(.W(`RBCS_CNT_W)) u_wd (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(wd_trigger_i && !wd_busy),
    .step_i(1'b1),
    .cnt_i({2'h0, `RBCS_WD_PULSE_CYC}), // RULE3
    .busy_o(wd_busy),
    .done_o()
  );

  rbcs_delay #(.W(`RBCS_CNT_W)) u_bus (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(rel_start),
    .step_i(1'b1),
    .cnt_i({2'h0, `RBCS_BUS_VALID_CYC}), // RULE4
    .busy_o(),
    .done_o(bus_done)
  );

  rbcs_delay #(.W(`RBCS_CNT_W)) u_strap (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(rel_start),
    .step_i(1'b1),
    .cnt_i({2'h0, `RBCS_STRAP_HOLD_CYC}), // RULE5 RULE6
    .busy_o(),
    .done_o(strap_done)
  );

  // Boot wait advances every cycle with the PLL off and every other cycle otherwise,
  // in bypass and with the PLL selected alike; under debug the current selection applies
  assign boot_step = (sys_clk_sel_o == `RBCS_SYS_DIRECT) ? 1'b1 : sys_ph_ff; // RULE8 RULE10

  rbcs_delay #(.W(`RBCS_CNT_W)) u_boot (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(rel_start || (debug_boot_i && state_ff == S_RUN)),
    .step_i(boot_step),
    .cnt_i({2'h0, `RBCS_BOOT_SYS_CYC}), // RULE8
    .busy_o(),
    .done_o(boot_done)
  );

  rbcs_delay #(.W(`RBCS_CNT_W)) u_lock (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(mult_wr_i && !pll_disabled_o && !in_reset),
    .step_i(1'b1),
    .cnt_i(`RBCS_PLL_LOCK_CYC), // RULE12
    .busy_o(lock_busy),
    .done_o(lock_done)
  );

  // Sequencer
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_RESET:
        if (!in_reset)
          nxt_state = S_STRAP;
      S_STRAP:
        if (strap_done)
          nxt_state = S_BOOT;
      S_BOOT:
        if (boot_done)
          nxt_state = S_RUN;
      S_RUN:
        nxt_state = S_RUN;
      default:
        nxt_state = S_RESET;
    endcase
    if (in_reset)
      nxt_state = S_RESET;
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_ff <= S_RESET;
      sys_ph_ff <= 1'b0;
      bus_valid_o <= 1'b0;
      pll_disabled_o <= 1'b0;
      memory_map_mode_o <= 1'b0;
      boot_mode_o <= 4'h0;
      boot_sampled_o <= 1'b0;
      boot_to_rom_o <= 1'b0;
      pll_multiplier_reg_o <= `RBCS_MULT_RST;
      sys_clk_sel_o <= `RBCS_SYS_BYPASS;
      pll_locked_o <= 1'b0;
      xif_timing_clock_half_o <= `RBCS_XIF_TIM_HALF_RST;
      xif_clock_out_half_o <= `RBCS_XIF_OUT_HALF_RST;
      clkout_div_o <= `RBCS_CLKOUT_DIV_RST; // RULE11
    end
    else
    begin
      state_ff <= nxt_state;
      sys_ph_ff <= !sys_ph_ff;
      if (in_reset)
      begin
        // Straps follow the pins in reset; the last sample lands inside the hold window
        pll_disabled_o <= !pll_disable_strap_n_i; // RULE5 RULE16
        memory_map_mode_o <= memory_map_mode_strap_i; // RULE6
        bus_valid_o <= 1'b0;
        boot_sampled_o <= 1'b0;
        pll_multiplier_reg_o <= `RBCS_MULT_RST;
        pll_locked_o <= 1'b0;
        xif_timing_clock_half_o <= `RBCS_XIF_TIM_HALF_RST; // RULE11
        xif_clock_out_half_o <= `RBCS_XIF_OUT_HALF_RST; // RULE11
      end
      else
      begin
        if (bus_done)
          bus_valid_o <= 1'b1; // RULE4
        if (debug_boot_i && state_ff == S_RUN)
          boot_sampled_o <= 1'b0; // RULE10
        if (mult_wr_i && !pll_disabled_o)
          pll_multiplier_reg_o <= mult_i; // RULE15
        if (lock_done)
          pll_locked_o <= 1'b1; // RULE12
        else if (mult_wr_i)
          pll_locked_o <= 1'b0;
        if (xif_wr_i)
        begin
          xif_timing_clock_half_o <= xif_timing_clock_half_i;
          xif_clock_out_half_o <= xif_clock_out_half_i;
        end
      end
      if (boot_done && !in_reset)
      begin
        boot_mode_o <= boot_mode_i; // RULE7 RULE8
        boot_sampled_o <= 1'b1;
        boot_to_rom_o <= (boot_mode_i != 4'hf); // RULE9
      end
      // System clock selection code: direct, bypass or PLL
      if (pll_disabled_o)
        sys_clk_sel_o <= `RBCS_SYS_DIRECT; // RULE16
      else if (pll_multiplier_reg_o != `RBCS_MULT_RST && !lock_busy)
        sys_clk_sel_o <= `RBCS_SYS_PLL; // RULE15
      else
        sys_clk_sel_o <= `RBCS_SYS_BYPASS; // RULE14
      // Output clock division relative to the system clock
      clkout_div_o <= {2'h0, xif_timing_clock_half_o && xif_clock_out_half_o,
        xif_timing_clock_half_o ^ xif_clock_out_half_o,
        !(xif_timing_clock_half_o || xif_clock_out_half_o)}; // RULE11
    end
  end
endmodule // rbcs_seq

// *** testbench/rbcs_seq_asserts.sv ***
/* Checker for rbcs_seq: start-up timing, watchdog pulse, boot choice, clock selection.
   Assumes one clock domain with a synchronous reset; bound to every rbcs_seq. */
`timescale 1ns/10ps
module rbcs_seq_chk (
  // Clock, reset and inputs
  input wire clk_i,
  input wire srst_i,
  input wire ext_reset_n_i,
  input wire mult_wr_i,
  input wire debug_boot_i,
  // Watched outputs
  input wire core_reset_o,
  input wire wd_reset_oe_n_o,
  input wire bus_valid_o,
  input wire pll_disabled_o,
  input wire [3:0] boot_mode_o,
  input wire boot_sampled_o,
  input wire boot_to_rom_o,
  input wire [3:0] pll_multiplier_reg_o,
  input wire [1:0] sys_clk_sel_o,
  input wire pll_locked_o,
  input wire xif_timing_clock_half_o,
  input wire xif_clock_out_half_o
);
  int rc, wc, lc;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Cycles since release or boot restart, watchdog drive time, cycles since multiplier write
  always @(posedge clk_i)
  begin
    rc <= (ext_reset_n_i && wd_reset_oe_n_o && !debug_boot_i) ? rc + 1 : 0;
    wc <= wd_reset_oe_n_o ? 0 : wc + 1;
    lc <= mult_wr_i ? 0 : lc + 1;
  end
  AST_WD_PULSE: assert property ($rose(wd_reset_oe_n_o) |-> wc >= 510 && wc <= 514)
    else $error("watchdog pulse length off");
  AST_BUS_WAIT: assert property ($rose(bus_valid_o) |-> rc >= 30 && rc <= 40)
    else $error("bus start delay off");
  AST_BOOT_WAIT: assert property ($rose(boot_sampled_o) |->
    (pll_disabled_o ? rc >= 1258 && rc <= 1300 : rc >= 2518 && rc <= 2560))
    else $error("boot sampling delay off");
  AST_BOOT_DEST: assert property (boot_sampled_o |-> boot_to_rom_o == (boot_mode_o != 4'hf))
    else $error("boot branch wrong");
  AST_XIF_RST: assert property ($rose(ext_reset_n_i) |-> xif_timing_clock_half_o && xif_clock_out_half_o)
    else $error("divide bits not set by reset");
  AST_SYNC: assert property ($rose(ext_reset_n_i) |-> core_reset_o ##1 core_reset_o)
    else $error("reset release not synchronised");
  AST_BYPASS: assert property (bus_valid_o && !pll_locked_o |-> sys_clk_sel_o == (pll_disabled_o ? 2'h0 : 2'h1))
    else $error("start clock selection wrong");
  AST_PLL_ON: assert property ($rose(pll_locked_o) |-> pll_multiplier_reg_o != 4'h0 ##[0:2] sys_clk_sel_o == 2'h2)
    else $error("pll clock not selected");
  AST_LOCK: assert property ($rose(pll_locked_o) |-> lc >= 131068 && lc <= 131076)
    else $error("lock wait wrong");
  AST_REFUSE: assert property (pll_disabled_o && mult_wr_i |=> pll_multiplier_reg_o == 4'h0)
    else $error("multiplier taken while pll off");
  cover property ($rose(pll_locked_o));
  cover property ($rose(boot_sampled_o) && pll_disabled_o);
  cover property ($fell(wd_reset_oe_n_o));
endmodule // rbcs_seq_chk

bind rbcs_seq rbcs_seq_chk rbcs_seq_chk_i (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .ext_reset_n_i(ext_reset_n_i),
  .mult_wr_i(mult_wr_i),
  .debug_boot_i(debug_boot_i),
  .core_reset_o(core_reset_o),
  .wd_reset_oe_n_o(wd_reset_oe_n_o),
  .bus_valid_o(bus_valid_o),
  .pll_disabled_o(pll_disabled_o),
  .boot_mode_o(boot_mode_o),
  .boot_sampled_o(boot_sampled_o),
  .boot_to_rom_o(boot_to_rom_o),
  .pll_multiplier_reg_o(pll_multiplier_reg_o),
  .sys_clk_sel_o(sys_clk_sel_o),
  .pll_locked_o(pll_locked_o),
  .xif_timing_clock_half_o(xif_timing_clock_half_o),
  .xif_clock_out_half_o(xif_clock_out_half_o)
);

// *** testbench/rbcs_sup.sv ***
/* Board reset supervisor: holds reset low with straps and boot pins applied.
   Assumes req_i is raised for a new reset; pins stay put until the next one. */
`timescale 1ns/10ps
module rbcs_sup #(
  parameter int LOW_MIN = 16
) (
  // Clock and command
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [5:0] cfg_i,
  // Board pins
  output logic ext_reset_n_o,
  output logic [5:0] pins_o
);
  int n = 0;
  // Clock runs free throughout, so it is stable long before release
  always @(posedge clk_i)
  begin
    if (req_i)
    begin
      ext_reset_n_o <= 1'b0;
      pins_o <= cfg_i;
      n <= 0;
    end
    else if (n < LOW_MIN)
      n <= n + 1;
    else
      ext_reset_n_o <= 1'b1;
  end
endmodule // rbcs_sup

// *** testbench/testbench.sv ***
/* Self-checking bench for rbcs_seq with a board supervisor model.
   Assumes the 200 MHz input clock is the only clock. */
`timescale 1ns/10ps
module testbench;
  logic clk_i, srst_i, ext_reset_n_i, req;
  logic wd_trigger_i, debug_boot_i, mult_wr_i, xif_wr_i, xif_timing_clock_half_i;
  logic xif_clock_out_half_i, core_reset_o, wd_reset_n_o, wd_reset_oe_n_o, bus_valid_o;
  logic pll_disabled_o, memory_map_mode_o, boot_sampled_o, boot_to_rom_o, pll_locked_o;
  logic xif_timing_clock_half_o, xif_clock_out_half_o;
  logic [3:0] mult_i, boot_mode_o, pll_multiplier_reg_o;
  logic [1:0] sys_clk_sel_o;
  logic [4:0] clkout_div_o;
  logic [5:0] cfg, pins;
  int err_count = 0, checks = 0, n;
  rbcs_seq rbcs_seq_i (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ext_reset_n_i(ext_reset_n_i),
    .pll_disable_strap_n_i(pins[5]),
    .memory_map_mode_strap_i(pins[4]),
    .boot_mode_i(pins[3:0]),
    .wd_trigger_i(wd_trigger_i),
    .debug_boot_i(debug_boot_i),
    .mult_wr_i(mult_wr_i),
    .mult_i(mult_i),
    .xif_wr_i(xif_wr_i),
    .xif_timing_clock_half_i(xif_timing_clock_half_i),
    .xif_clock_out_half_i(xif_clock_out_half_i),
    .core_reset_o(core_reset_o),
    .wd_reset_n_o(wd_reset_n_o),
    .wd_reset_oe_n_o(wd_reset_oe_n_o),
    .bus_valid_o(bus_valid_o),
    .pll_disabled_o(pll_disabled_o),
    .memory_map_mode_o(memory_map_mode_o),
    .boot_mode_o(boot_mode_o),
    .boot_sampled_o(boot_sampled_o),
    .boot_to_rom_o(boot_to_rom_o),
    .pll_multiplier_reg_o(pll_multiplier_reg_o),
    .sys_clk_sel_o(sys_clk_sel_o),
    .pll_locked_o(pll_locked_o),
    .xif_timing_clock_half_o(xif_timing_clock_half_o),
    .xif_clock_out_half_o(xif_clock_out_half_o),
    .clkout_div_o(clkout_div_o)
  );
  rbcs_sup rbcs_sup_i (.clk_i(clk_i), .req_i(req), .cfg_i(cfg), .ext_reset_n_o(ext_reset_n_i),
    .pins_o(pins));
  task ck(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e)
    begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, a, e);
    end
  endtask
  task close_out;
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One-cycle strobe: m bits are debug, watchdog, xif write, multiplier write
  task pulse(input logic [3:0] m);
    @(posedge clk_i);
    {debug_boot_i, wd_trigger_i, xif_wr_i, mult_wr_i} <= m;
    @(posedge clk_i);
    {debug_boot_i, wd_trigger_i, xif_wr_i, mult_wr_i} <= 4'h0;
  endtask
  // Waits for a level: 0 watchdog drive released, 1 lock, 2 boot sampled
  task wait_hi(input int w, input int lim);
    n = 0;
    while ((w == 0 ? wd_reset_oe_n_o : (w == 1 ? pll_locked_o : boot_sampled_o)) !== 1'b1
      && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask
  // Reset with straps c, then follow start-up up to boot-pin sampling
  task boot(input logic [5:0] c, input int lo, input int hi);
    @(posedge clk_i);
    req <= 1'b1;
    cfg <= c;
    repeat (4) @(posedge clk_i);
    req <= 1'b0;
    @(posedge ext_reset_n_i);
    @(negedge clk_i);
    ck(core_reset_o, 1);
    n = 0;
    while (!bus_valid_o && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    ck(n >= 30 && n <= 40, 1);
    ck(xif_timing_clock_half_o & xif_clock_out_half_o, 1);
    ck(clkout_div_o, 5'h04);
    ck(sys_clk_sel_o, c[5] ? 2'h1 : 2'h0);
    ck({pll_disabled_o, memory_map_mode_o}, {!c[5], c[4]});
    while (!boot_sampled_o && n < 3000)
    begin
      @(negedge clk_i);
      n++;
    end
    ck(n >= lo && n <= hi, 1);
    ck(boot_to_rom_o, c[3:0] != 4'hf);
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (160000) @(posedge clk_i);
    err_count++;
    close_out;
  end
  initial
  begin
    {srst_i, req, cfg} = 8'hff;
    {wd_trigger_i, debug_boot_i, mult_wr_i, mult_i, xif_wr_i} = 8'h00;
    {xif_timing_clock_half_i, xif_clock_out_half_i} = 2'h0;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    boot(6'h3f, 2518, 2560);
    boot(6'h05, 1258, 1300);
    pulse(4'h8);
    @(negedge clk_i);
    ck(boot_sampled_o, 0);
    wait_hi(2, 1400);
    ck(n >= 1258 && n <= 1300, 1);
    @(posedge clk_i);
    mult_i <= 4'h3;
    pulse(4'h1);
    @(negedge clk_i);
    ck({pll_multiplier_reg_o, sys_clk_sel_o}, 6'h00);
    boot(6'h2a, 2518, 2560);
    pulse(4'h2);
    @(negedge clk_i);
    ck({xif_timing_clock_half_o, xif_clock_out_half_o}, 2'h0);
    @(negedge clk_i);
    ck(clkout_div_o, 5'h01);
    pulse(4'h4);
    n = 0;
    while (wd_reset_oe_n_o && n < 8)
    begin
      @(negedge clk_i);
      n++;
    end
    ck(wd_reset_n_o, 0);
    wait_hi(0, 600);
    ck(n >= 510 && n <= 514, 1);
    ck(core_reset_o, 1);
    boot(6'h3f, 2518, 2560);
    pulse(4'h1);
    wait_hi(1, 140000);
    ck(n >= 131068 && n <= 131076, 1);
    repeat (3) @(negedge clk_i);
    ck({pll_multiplier_reg_o, sys_clk_sel_o}, 6'h0e);
    close_out;
  end
endmodule // testbench
